//--- core/conv_pkg.sv
// Shared constants and types for the converter sequencer and serial readout
package conv_pkg;
  localparam int          RES_BITS      = 16;
  localparam logic [15:0] ABORT_WORD    = 16'hFF00;
  localparam logic [15:0] RESULT_RST    = 16'h0000;
  localparam int          CLK_MHZ       = 100;
  localparam int          CONV_TIME_NS  = 1100;
  // Longest time rounds down
  localparam int          CONV_CYCLES   = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int          SCLK_MAX_MHZ  = 40;
  localparam int          CNT_W         = 12;
  localparam int          BIT_W         = 5;

  typedef enum logic [2:0] {
    ST_WAIT   = 3'b000,
    ST_NAP    = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b011
  } conv_state_t;

  typedef struct packed {
    logic convert_start_n;
    logic cs_n;
    logic frame_sync;
    logic sclk;
  } host_pins_t;
endpackage

//--- core/pin_sync.sv
// Two-flop synchroniser for a bundle of host pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  initial if (W < 1) $error("pin_sync width must be positive");

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
endmodule

//--- core/sar_seq.sv
// Conversion sequencer and serial result readout of the converter
// Contract
// - Falling qualified start begins conversion
// - Qualified start latches start while selected
// - Start high and selected begins sampling
// - Start present at end: sample immediately
// - No start at end: wait or nap
// - Qualified start low at end: nap
// - Falling qualified start mid-conversion aborts
// - Aborted conversion reads fixed abort word
// - Reads anytime; during conversion, previous result
// - Select framing: MSB at select fall, shift
// - Select re-low restarts frame from MSB
// - Frame-sync framing: MSB at rise, shift
// - Frame sync high at busy fall reloads
// - Frame-sync rise restarts frame from MSB
// - Conversion ends within maximum conversion time
// - Serial clock up to rated frequency
// - Busy high exactly during conversion
// - Results in two's complement
`timescale 1ns/1ps
module sar_seq #(
  parameter int CONV_CYCLES = conv_pkg::CONV_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        convert_start_n,
  input  wire logic        cs_n,
  input  wire logic        frame_sync,
  input  wire logic        sclk,
  input  wire logic [15:0] analog_code,
  output logic             busy,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             nap
);
  initial if (CONV_CYCLES < 2 || CONV_CYCLES >= (1 << conv_pkg::CNT_W))
    $error("CONV_CYCLES out of range");

  conv_pkg::host_pins_t pins_raw;
  conv_pkg::host_pins_t pins_s;
  conv_pkg::host_pins_t pins_d_r;
  conv_pkg::conv_state_t state_r;
  conv_pkg::conv_state_t state_nxt;
  logic                          qual_r;
  logic                          qual_d_r;
  logic [conv_pkg::CNT_W-1:0]    cnt_r;
  logic [15:0]                   result_r;
  logic [15:0]                   shift_r;
  logic [conv_pkg::BIT_W-1:0]    bits_r;
  logic                          armed_r;
  logic                          busy_d_r;
  logic [conv_pkg::CNT_W-1:0]    busy_len_r;

  assign pins_raw = '{convert_start_n: convert_start_n, cs_n: cs_n, frame_sync: frame_sync, sclk: sclk};

  pin_sync #(
    .W      (4),
    .RST_VAL(4'hE)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .din    (pins_raw),
    .dout   (pins_s)
  );

  wire qual_nxt    = pins_s.cs_n ? qual_r : pins_s.convert_start_n;
  wire qual_fall   = qual_d_r & ~qual_r;
  wire sample_cmd  = pins_s.convert_start_n & ~pins_s.cs_n;
  wire conv_done   = (state_r == conv_pkg::ST_CONV) && (cnt_r == CONV_CYCLES[conv_pkg::CNT_W-1:0] - 12'h001);
  wire busy_fall   = busy_d_r & ~busy;
  wire cs_fall     = pins_d_r.cs_n & ~pins_s.cs_n;
  wire fs_rise     = ~pins_d_r.frame_sync & pins_s.frame_sync;
  wire fs_fall     = pins_d_r.frame_sync & ~pins_s.frame_sync;
  wire sclk_rise   = ~pins_d_r.sclk & pins_s.sclk;
  wire sclk_fall   = pins_d_r.sclk & ~pins_s.sclk;
  wire fs_mode     = ~pins_s.cs_n & ~pins_d_r.cs_n;
  // Select fall always starts a frame; frame sync rise starts one only after select has been low for two samples
  wire frame_start = cs_fall | (fs_mode & fs_rise);
  wire fs_reload   = fs_mode & pins_s.frame_sync & busy_fall;
  wire arm_evt     = sclk_fall & (pins_s.frame_sync ? 1'b1 : ~fs_rise);
  wire shift_evt   = sclk_rise & armed_r & (bits_r != 5'h0F) & ~pins_s.cs_n;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      conv_pkg::ST_WAIT,
      conv_pkg::ST_NAP:
        if (sample_cmd)
          state_nxt = conv_pkg::ST_SAMPLE;
      conv_pkg::ST_SAMPLE:
        if (qual_fall)
          state_nxt = conv_pkg::ST_CONV;
      conv_pkg::ST_CONV:
        if (qual_fall)
          state_nxt = conv_pkg::ST_WAIT;
        else if (conv_done)
        begin
          if (sample_cmd)
            state_nxt = conv_pkg::ST_SAMPLE;
          else if (!qual_r)
            state_nxt = conv_pkg::ST_NAP;
          else
            state_nxt = conv_pkg::ST_WAIT;
        end
      default:
        state_nxt = conv_pkg::ST_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      state_r  <= conv_pkg::ST_WAIT;
      qual_r   <= 1'b1;
      qual_d_r <= 1'b1;
      pins_d_r <= 4'hE;
      cnt_r    <= '0;
      busy     <= 1'b0;
      busy_d_r <= 1'b0;
      nap      <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      qual_r   <= qual_nxt;
      qual_d_r <= qual_r;
      pins_d_r <= pins_s;
      cnt_r    <= (state_nxt == conv_pkg::ST_CONV && state_r == conv_pkg::ST_CONV) ? cnt_r + 12'h001 : '0;
      busy     <= (state_nxt == conv_pkg::ST_CONV);
      busy_d_r <= busy;
      nap      <= (state_nxt == conv_pkg::ST_NAP);
    end

  // Result updates only when busy falls, so a read during conversion sees the old word
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      result_r <= conv_pkg::RESULT_RST;
    else if (state_r == conv_pkg::ST_CONV && qual_fall)
      result_r <= conv_pkg::ABORT_WORD;
    else if (conv_done)
      result_r <= analog_code;

  // Readout shift path; each host clock phase must span more than one ref_clk period to be seen
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      shift_r <= '0;
      bits_r  <= '0;
      armed_r <= 1'b0;
      sdo     <= 1'b0;
      sdo_oe  <= 1'b0;
    end
    else
    begin
      sdo_oe <= ~pins_s.cs_n;
      if (frame_start || fs_reload)
      begin
        shift_r <= fs_reload ? analog_code_latched() : result_r;
        sdo     <= fs_reload ? analog_code_latched_msb() : result_r[15];
        bits_r  <= '0;
        armed_r <= 1'b0;
      end
      else
      begin
        if (fs_mode && fs_fall)
          armed_r <= 1'b0;
        else if (arm_evt && !armed_r)
          armed_r <= 1'b1;
        if (shift_evt)
        begin
          shift_r <= {shift_r[14:0], 1'b0};
          sdo     <= shift_r[14];
          bits_r  <= bits_r + 5'h01;
        end
      end
    end

  // Busy length is counted apart from cnt_r so the bound check does not trust the counter it guards
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      busy_len_r <= '0;
    else if (busy)
      busy_len_r <= busy_len_r + 12'h001;
    else
      busy_len_r <= '0;

  function automatic logic [15:0] analog_code_latched();
    analog_code_latched = result_r;
  endfunction

  function automatic logic analog_code_latched_msb();
    analog_code_latched_msb = result_r[15];
  endfunction

  busy_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(busy) |-> busy [*2]) else $error("busy pulse too short");
  conv_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == conv_pkg::ST_CONV) |-> (cnt_r < CONV_CYCLES)) else $error("conversion overran");
  start_conv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == conv_pkg::ST_SAMPLE && qual_fall) |=> busy) else $error("no conversion on start");
  abort_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == conv_pkg::ST_CONV && qual_fall) |=> (result_r == conv_pkg::ABORT_WORD && state_r == conv_pkg::ST_WAIT))
    else $error("abort not handled");
  nap_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (conv_done && !qual_fall && !sample_cmd && !qual_r) |=> nap) else $error("nap not entered");
  b2b_sample_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (conv_done && !qual_fall && sample_cmd) |=> (state_r == conv_pkg::ST_SAMPLE)) else $error("no back-to-back");
  wake_sample_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((state_r == conv_pkg::ST_WAIT || state_r == conv_pkg::ST_NAP) && sample_cmd) |=> (state_r == conv_pkg::ST_SAMPLE))
    else $error("sampling not started");
  msb_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    frame_start |=> (sdo == $past(result_r[15]) && bits_r == 5'h00)) else $error("frame not restarted at MSB");
  bit_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bits_r == 5'h0F && !frame_start && !fs_reload) |=> $stable(sdo)) else $error("last bit not held");
  qual_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pins_s.cs_n |=> $stable(qual_r)) else $error("qualified start moved while deselected");

  // Busy is a registered copy of the conversion state, never a cycle apart
  busy_state_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy == (state_r == conv_pkg::ST_CONV))
    else $error("busy differs from conversion state");

  // Nap output follows the nap state
  nap_state_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    nap == (state_r == conv_pkg::ST_NAP))
    else $error("nap differs from nap state");

  // End without sample command and with qualified start high goes to wait
  wait_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (conv_done && !qual_fall && !sample_cmd && qual_r) |=> (state_r == conv_pkg::ST_WAIT))
    else $error("wait not entered");

  // Conversion never outlasts its budget
  conv_time_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy |-> (busy_len_r < CONV_CYCLES))
    else $error("conversion too long");

  // Readers during a conversion keep seeing the previous word
  result_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (busy && !qual_fall && !conv_done) |=> $stable(result_r))
    else $error("result moved during conversion");

  // A finished conversion stores the code unchanged
  result_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (conv_done && !qual_fall) |=> (result_r == $past(analog_code)))
    else $error("result not stored");

  // Each shift moves exactly one bit
  shift_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (shift_evt && !frame_start && !fs_reload) |=> (sdo == $past(shift_r[14]) && bits_r == $past(bits_r) + 5'h01))
    else $error("shift step wrong");

  // No shift before the arming clock fall
  arm_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!armed_r && !frame_start && !fs_reload) |=> $stable(bits_r))
    else $error("shift before arming");

  // Never more than sixteen bits per frame
  bit_limit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    bits_r <= 5'h0F)
    else $error("bit count overran");

  // Reload at busy fall restarts from the new MSB
  fs_reload_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fs_reload |=> (sdo == $past(result_r[15]) && bits_r == 5'h00))
    else $error("reload at busy fall missed");

  // Deselected port stays frozen
  deselect_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pins_s.cs_n |=> ($stable(bits_r) && $stable(sdo)))
    else $error("output moved while deselected");

  // Qualified start tracks the pin while selected
  qual_track_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !pins_s.cs_n |=> (qual_r == $past(pins_s.convert_start_n)))
    else $error("qualified start not latched");

  // Sampling lasts until a falling qualified start
  sample_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == conv_pkg::ST_SAMPLE && !qual_fall) |=> (state_r == conv_pkg::ST_SAMPLE))
    else $error("sampling left early");

  // Idle states hold until a sample command
  idle_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((state_r == conv_pkg::ST_WAIT || state_r == conv_pkg::ST_NAP) && !sample_cmd) |=> $stable(state_r))
    else $error("idle state left without command");

  // Output driven while selected
  oe_track_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !pins_s.cs_n |=> sdo_oe)
    else $error("output not enabled while selected");

  // Only the four coded states are ever reached
  state_legal_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !state_r[2])
    else $error("illegal state");
endmodule

//--- test/host_model.sv
// Host side of the serial read port: select, frame sync and serial clock
`timescale 1ns/1ps
module host_model (
  input  wire logic sdo,
  output logic      cs_n,
  output logic      frame_sync,
  output logic      sclk
);
  initial
  begin
    cs_n = 1'b1;
    frame_sync = 1'b1;
    sclk = 1'b0;
  end
  // Pins move only between frames, so the quiet zones stay clear
  task automatic pins(input logic c, input logic f);
    cs_n = c;
    frame_sync = f;
    #100;
  endtask
  // Clock rests low outside frames; one arming fall precedes the first shift
  task automatic frame(input int n, output logic [15:0] w);
    w = 16'h0000;
    sclk = 1'b1;
    #62.5 sclk = 1'b0;
    #62.5 w = {w[14:0], sdo};
    for (int i = 1; i < n; i++)
    begin
      sclk = 1'b1;
      #62.5 w = {w[14:0], sdo};
      sclk = 1'b0;
      #62.5;
    end
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the conversion sequencer and serial readout
`timescale 1ns/1ps
module testbench;
  // Short conversion keeps the run brief but still spans a partial frame
  localparam int CC = 30;
  logic        ref_clk, sys_rst, convert_start_n, busy, sdo, sdo_oe, nap;
  logic        cs_n, frame_sync, sclk;
  logic [15:0] analog_code, w;
  int          err_count, check_count, cyc;
  sar_seq #(.CONV_CYCLES(CC)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .convert_start_n(convert_start_n), .cs_n(cs_n), .frame_sync(frame_sync),
    .sclk(sclk), .analog_code(analog_code), .busy(busy), .sdo(sdo),
    .sdo_oe(sdo_oe), .nap(nap));
  host_model host (.sdo(sdo), .cs_n(cs_n), .frame_sync(frame_sync), .sclk(sclk));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (!ok)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_busy(input logic v, output int n);
    n = 0;
    while (busy !== v && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic t_nap();
    int n;
    analog_code = 16'h8001;
    host.pins(1'b0, 1'b1);
    convert_start_n = 1'b0;
    wait_busy(1'b1, n);
    chk(n <= 5, "busy late");
    wait_busy(1'b0, n);
    chk(n >= CC - 1 && n <= CC + 1, "busy length");
    tick(4);
    chk(nap === 1'b1, "no nap");
    host.pins(1'b1, 1'b1);
    host.pins(1'b0, 1'b1);
    host.frame(17, w);
    tick(1);
    chk(w === 16'h0003, "select frame word");
    $display("t_nap done");
  endtask
  task automatic t_wait();
    int n;
    convert_start_n = 1'b1;
    tick(6);
    chk(nap === 1'b0, "sample not entered");
    convert_start_n = 1'b0;
    wait_busy(1'b1, n);
    convert_start_n = 1'b1;
    tick(2);
    host.pins(1'b1, 1'b1);
    wait_busy(1'b0, n);
    tick(4);
    chk(nap === 1'b0 && busy === 1'b0, "not wait");
    convert_start_n = 1'b0;
    tick(10);
    chk(busy === 1'b0, "unselected start taken");
    $display("t_wait done");
  endtask
  task automatic t_b2b_abort();
    int n;
    convert_start_n = 1'b1;
    host.pins(1'b0, 1'b1);
    convert_start_n = 1'b0;
    wait_busy(1'b1, n);
    convert_start_n = 1'b1;
    wait_busy(1'b0, n);
    tick(2);
    chk(nap === 1'b0, "nap after sample command");
    convert_start_n = 1'b0;
    wait_busy(1'b1, n);
    chk(n <= 5, "no back to back start");
    tick(3);
    convert_start_n = 1'b1;
    tick(5);
    convert_start_n = 1'b0;
    wait_busy(1'b0, n);
    chk(n <= 8, "abort ignored");
    tick(4);
    chk(nap === 1'b0 && busy === 1'b0, "abort not wait");
    host.pins(1'b1, 1'b1);
    host.pins(1'b0, 1'b1);
    host.frame(5, w);
    tick(1);
    host.pins(1'b1, 1'b1);
    host.pins(1'b0, 1'b1);
    host.frame(16, w);
    chk(w === conv_pkg::ABORT_WORD, "abort word");
    $display("t_b2b_abort done");
  endtask
  task automatic t_fs();
    int n;
    analog_code = 16'h1234;
    host.pins(1'b0, 1'b0);
    convert_start_n = 1'b1;
    tick(4);
    convert_start_n = 1'b0;
    wait_busy(1'b1, n);
    host.pins(1'b0, 1'b1);
    host.pins(1'b0, 1'b0);
    host.frame(16, w);
    chk(w === conv_pkg::ABORT_WORD, "previous result");
    analog_code = 16'hA5C3;
    convert_start_n = 1'b1;
    tick(4);
    convert_start_n = 1'b0;
    wait_busy(1'b1, n);
    host.pins(1'b0, 1'b1);
    chk(sdo === 1'b0, "old msb at sync rise");
    wait_busy(1'b0, n);
    tick(5);
    chk(sdo === 1'b1, "no reload at busy fall");
    host.pins(1'b0, 1'b0);
    host.frame(16, w);
    chk(w === 16'hA5C3, "sync frame word");
    $display("t_fs done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    convert_start_n = 1'b1;
    analog_code = 16'h0000;
    tick(8);
    sys_rst = 1'b0;
    tick(4);
    t_nap();
    t_wait();
    t_b2b_abort();
    t_fs();
    conclude();
  end
endmodule
